// ### pcpsc_pkg.sv
// shared constants, types and decode functions of the pixel clock block
`default_nettype none
package pcpsc_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  // separator threshold unit and default multiplier
  localparam int SEP_UNIT_NS = 200;
  localparam int SEP_N_DEFAULT = 5;
  // regenerator holdoff after an accepted line edge (least time)
  localparam int REGEN_HOLD_NS = 1000;
  localparam int REGEN_HOLD_CYC =
    (REGEN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // phase steps of the delay line
  localparam int PHASE_TAPS = 32;

  // ************************************************************
  // frequency word: pixels per system clock, 16 fraction bits
  // ************************************************************
  localparam int FW_W = 20;
  localparam int FW_FRAC = 16;
  localparam int BAND0_MIN_MHZ = 10;
  localparam int GEAR_OFF_MIN_MHZ = 18;
  localparam int BAND1_MIN_MHZ = 31;
  localparam int BAND2_MIN_MHZ = 62;
  localparam int BAND3_MIN_MHZ = 124;
  localparam int BAND3_MAX_MHZ = 170;
  localparam int FW_RESET_MHZ = 25;

  // ************************************************************
  // charge pump currents in microamps
  // ************************************************************
  localparam logic [10:0] PUMP_UA_0 = 11'h032;
  localparam logic [10:0] PUMP_UA_1 = 11'h064;
  localparam logic [10:0] PUMP_UA_2 = 11'h096;
  localparam logic [10:0] PUMP_UA_3 = 11'h0FA;
  localparam logic [10:0] PUMP_UA_4 = 11'h15E;
  localparam logic [10:0] PUMP_UA_5 = 11'h1F4;
  localparam logic [10:0] PUMP_UA_6 = 11'h2EE;
  localparam logic [10:0] PUMP_UA_7 = 11'h5DC;

  // ************************************************************
  // configuration carrier
  // ************************************************************
  typedef struct packed {
    logic [11:0] divisor;
    logic vco_band_sel_hi;
    logic vco_band_sel_lo;
    logic vco_low_gear;
    logic pump_current_sel_2;
    logic pump_current_sel_1;
    logic pump_current_sel_0;
    logic [4:0] phase_tap;
    logic [1:0] line_sync_pol;
    logic [1:0] coast_pol;
    logic [4:0] slice_level;
    logic sep_src_slicer;
    logic filt_ref_sel;
    logic int_coast_en;
    logic ext_clk_sel;
    logic green_out_inv;
  } pcpsc_cfg_type;

  // ************************************************************
  // decode functions
  // ************************************************************
  // frequency in MHz to frequency word
  function automatic logic [FW_W-1:0] fw_of(input int mhz);
    fw_of = FW_W'((mhz * (2 ** FW_FRAC)) / CLK_MHZ);
  endfunction

  // lower edge of a VCO band, gear widens band 00 downward
  function automatic logic [FW_W-1:0] band_min(input logic [1:0] band,
                                               input logic gear);
    unique case (band)
      2'h0: band_min = gear ? fw_of(BAND0_MIN_MHZ)
                            : fw_of(GEAR_OFF_MIN_MHZ);
      2'h1: band_min = fw_of(BAND1_MIN_MHZ);
      2'h2: band_min = fw_of(BAND2_MIN_MHZ);
      2'h3: band_min = fw_of(BAND3_MIN_MHZ);
    endcase
  endfunction

  // upper edge of a VCO band
  function automatic logic [FW_W-1:0] band_max(input logic [1:0] band);
    unique case (band)
      2'h0: band_max = fw_of(BAND1_MIN_MHZ);
      2'h1: band_max = fw_of(BAND2_MIN_MHZ);
      2'h2: band_max = fw_of(BAND3_MIN_MHZ);
      2'h3: band_max = fw_of(BAND3_MAX_MHZ);
    endcase
  endfunction

  // charge pump code to current
  function automatic logic [10:0] pump_ua(input logic [2:0] code);
    unique case (code)
      3'h0: pump_ua = PUMP_UA_0;
      3'h1: pump_ua = PUMP_UA_1;
      3'h2: pump_ua = PUMP_UA_2;
      3'h3: pump_ua = PUMP_UA_3;
      3'h4: pump_ua = PUMP_UA_4;
      3'h5: pump_ua = PUMP_UA_5;
      3'h6: pump_ua = PUMP_UA_6;
      3'h7: pump_ua = PUMP_UA_7;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### pcpsc_tap_delay.sv
// phase step delay line shared by pixel clock and line sync
`timescale 1ns/1ps
`default_nettype none
module pcpsc_tap_delay #(
  parameter int W = 2,
  parameter int DEPTH = pcpsc_pkg::PHASE_TAPS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // data and tap
  input wire logic [W-1:0] in_w,
  input wire logic [$clog2(DEPTH)-1:0] sel,
  output logic [W-1:0] out_q
);

  logic [W-1:0] line_q [DEPTH];
  logic [W-1:0] line_d [DEPTH];
  logic [W-1:0] out_d;

  // ************************************************************
  // shift stages
  // ************************************************************
  assign line_d[0] = in_w;
  for (genvar i = 1; i < DEPTH; i++) begin : g_stage
    assign line_d[i] = line_q[i-1];
  end

  // both signals take the same tap
  always_comb begin
    out_d = line_q[sel]; // R22
  end

  // register stages and output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        line_q[i] <= '0;
      end
      out_q <= '0;
    end else begin
      line_q <= line_d;
      out_q <= out_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_tap_zero;
    @(posedge sys_clk) disable iff (rst)
      (!$past(rst, 2) && sel == '0 && $past(sel) == '0)
        |-> out_q == $past(in_w, 2);
  endproperty
  a_tap_zero: assert property (p_tap_zero) // R22
    else $error("tap zero does not give two cycle delay");

endmodule
`default_nettype wire

// ### pcpsc_top.sv
// line locked pixel clock control and sync front end
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R01) pixel clock equals line rate times the 12-bit divisor
// (R02) software programs divisor 2 to 4095, keeping clock in span
// (R03) line rate times divisor must lie between 10 and 170 MHz
// (R04) two-bit band select picks one of four overlapping VCO ranges
// (R05) software sets the low-range gear for targets of 18 MHz or less
// (R06) three-bit pump code picks 50 to 1500 microamps
// (R07) five-bit phase value shifts sampling clock in 32 steps
// (R08) regenerated line sync carries the same shift as the clock; the code shifts the divider wrap, regen is not delayed
// (R09) phase shift also applies to an external pixel clock
// (R10) coast holds loop frequency while line sync is missing
// (R11) internal coast derives from frame sync
// (R12) coast input polarity follows its two-bit setting
// (R13) line sync polarity follows its two-bit setting
// (R14) polarity value 1 means active high, 0 active low
// (R15) slicer makes composite sync, trigger level five bits
// (R16) separator takes frame sync from slicer or line sync input
// (R17) regenerated line sync used only for counting, never the loop
// (R18) outputs clock, field, line and frame sync, count, green sync
// (R19) divided pixel clock phase compared with line sync steers VCO
// (R20) select bit picks filtered line sync as loop reference
// (R21) coast suppresses phase updates, divider keeps counting
// (R22) phase step is one tap index shared by clock and line sync
module pcpsc_top #(
  parameter int SEP_N = pcpsc_pkg::SEP_N_DEFAULT,
  parameter int REGEN_HOLD = pcpsc_pkg::REGEN_HOLD_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration
  input wire pcpsc_pkg::pcpsc_cfg_type cfg,
  // sync and clock inputs
  input wire logic line_sync_input,
  input wire logic [7:0] green_sync_input,
  input wire logic coast_in,
  input wire logic ext_clk_in,
  // clock and sync outputs
  output logic pixel_clk_out,
  output logic line_sync_out,
  output logic frame_sync_out,
  output logic green_sync_out,
  output logic odd_field,
  output logic [11:0] lines_per_frame,
  // analog loop settings and status
  output logic [1:0] vco_band_out,
  output logic [10:0] pump_ua_out,
  output logic [19:0] freq_word_out
);

  localparam int SEP_CYC =
    SEP_N * pcpsc_pkg::SEP_UNIT_NS / pcpsc_pkg::CLK_PERIOD_NS;
  localparam logic [11:0] SEP_CYC_W = 12'(SEP_CYC);
  localparam logic [11:0] REGEN_RELOAD = 12'(REGEN_HOLD - 1);

  // ************************************************************
  // sync front end state
  // ************************************************************
  logic hs_q, hs_d, hs_prev_q, hs_prev_d;
  logic coast_act_q, coast_act_d;
  logic cs_q, cs_d;
  logic ext_q, ext_d;
  logic green_q, green_d;
  logic [11:0] sep_cnt_q, sep_cnt_d;
  logic vs_q, vs_d, vs_prev_q, vs_prev_d;
  logic [11:0] regen_cnt_q, regen_cnt_d;
  logic [11:0] lines_q, lines_d;
  logic [11:0] lines_out_q, lines_out_d;
  logic odd_q, odd_d;
  logic [15:0] gap_q, gap_d, per_q, per_d;
  logic sep_src, edge_raw, regen, vs_rise, filt_edge, ref_edge, coast;

  // ************************************************************
  // loop state
  // ************************************************************
  logic [15:0] acc_q, acc_d;
  logic [11:0] pix_cnt_q, pix_cnt_d;
  logic [19:0] fw_q, fw_d;
  logic wrap_q, wrap_d;
  logic clk_src_q, clk_src_d;
  logic [1:0] band_q, band_d;
  logic [10:0] pump_q, pump_d;
  logic [19:0] sum, step, fw_t, lo, hi;
  logic [12:0] cnt_n;
  logic [1:0] band_sel;
  logic [2:0] pump_sel;
  logic [11:0] half_div;

  assign band_sel = {cfg.vco_band_sel_hi, cfg.vco_band_sel_lo};
  assign pump_sel = {cfg.pump_current_sel_2, cfg.pump_current_sel_1,
                     cfg.pump_current_sel_0};
  assign half_div = {1'b0, cfg.divisor[11:1]};

  // ************************************************************
  // sync front end
  // ************************************************************
  // polarity, slicer, separator, regenerator, filter, counter
  always_comb begin
    hs_d = ~(line_sync_input ^ cfg.line_sync_pol[0]); // R13 R14
    coast_act_d = ~(coast_in ^ cfg.coast_pol[0]); // R12 R14
    cs_d = green_sync_input[7:3] < cfg.slice_level; // R15
    ext_d = ext_clk_in;
    green_d = cs_q ^ cfg.green_out_inv; // R18
    hs_prev_d = hs_q;
    vs_prev_d = vs_q;
    edge_raw = hs_q & ~hs_prev_q;
    // long pulses only pass, delayed by the threshold
    sep_src = cfg.sep_src_slicer ? cs_q : hs_q; // R16
    sep_cnt_d = '0;
    if (sep_src) begin
      sep_cnt_d = (sep_cnt_q == SEP_CYC_W) ? sep_cnt_q : sep_cnt_q + 12'h001;
    end
    vs_d = sep_src & (sep_cnt_q >= SEP_CYC_W);
    vs_rise = vs_q & ~vs_prev_q;
    // regenerator ignores edges inside its holdoff
    regen = edge_raw & (regen_cnt_q == 12'h000); // R17
    regen_cnt_d = (regen_cnt_q == 12'h000) ? 12'h000
                                           : regen_cnt_q - 12'h001;
    if (regen) begin
      regen_cnt_d = REGEN_RELOAD;
    end
    // filter rejects edges earlier than half the last period
    filt_edge = edge_raw & (gap_q >= {1'b0, per_q[15:1]});
    gap_d = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
    per_d = per_q;
    if (filt_edge) begin
      gap_d = 16'h0000;
      per_d = gap_q;
    end
    // lines per frame from regenerated edges, field from divider position
    lines_d = lines_q;
    lines_out_d = lines_out_q;
    odd_d = odd_q;
    if (vs_rise) begin
      lines_out_d = lines_q; // R18
      lines_d = 12'h000;
      odd_d = pix_cnt_q > half_div;
    end else if (regen && lines_q != 12'hFFF) begin
      lines_d = lines_q + 12'h001; // R17
    end
    coast = coast_act_q | (cfg.int_coast_en & vs_q); // R10 R11
    ref_edge = cfg.filt_ref_sel ? filt_edge : edge_raw; // R20
  end

  // register sync front end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_q <= 1'b0;
      hs_prev_q <= 1'b0;
      coast_act_q <= 1'b0;
      cs_q <= 1'b0;
      ext_q <= 1'b0;
      green_q <= 1'b0;
      sep_cnt_q <= 12'h000;
      vs_q <= 1'b0;
      vs_prev_q <= 1'b0;
      regen_cnt_q <= 12'h000;
      lines_q <= 12'h000;
      lines_out_q <= 12'h000;
      odd_q <= 1'b0;
      gap_q <= 16'h0000;
      per_q <= 16'h0000;
    end else begin
      hs_q <= hs_d;
      hs_prev_q <= hs_prev_d;
      coast_act_q <= coast_act_d;
      cs_q <= cs_d;
      ext_q <= ext_d;
      green_q <= green_d;
      sep_cnt_q <= sep_cnt_d;
      vs_q <= vs_d;
      vs_prev_q <= vs_prev_d;
      regen_cnt_q <= regen_cnt_d;
      lines_q <= lines_d;
      lines_out_q <= lines_out_d;
      odd_q <= odd_d;
      gap_q <= gap_d;
      per_q <= per_d;
    end
  end

  // ************************************************************
  // digital loop
  // ************************************************************
  // oscillator, divider, phase compare and band clamp
  always_comb begin
    sum = {4'h0, acc_q} + fw_q;
    acc_d = sum[15:0];
    cnt_n = {1'b0, pix_cnt_q} + {9'h000, sum[19:16]};
    wrap_d = cnt_n >= {1'b0, cfg.divisor}; // R01
    pix_cnt_d = wrap_d ? 12'(cnt_n - {1'b0, cfg.divisor}) : cnt_n[11:0];
    step = {9'h000, pcpsc_pkg::pump_ua(pump_sel)}; // R06
    fw_t = fw_q;
    // early divider slows, late divider speeds, coast holds
    if (ref_edge && !coast && pix_cnt_q != 12'h000) begin // R19 R21
      fw_t = (pix_cnt_q < half_div) ? fw_q - step : fw_q + step;
    end
    lo = pcpsc_pkg::band_min(band_sel, cfg.vco_low_gear); // R04 R05
    hi = pcpsc_pkg::band_max(band_sel); // R04
    fw_d = (fw_t < lo) ? lo : ((fw_t > hi) ? hi : fw_t);
    band_d = band_sel;
    pump_d = pcpsc_pkg::pump_ua(pump_sel); // R06
    clk_src_d = cfg.ext_clk_sel ? ext_q : acc_q[15]; // R09
  end

  // register loop state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      acc_q <= 16'h0000;
      pix_cnt_q <= 12'h000;
      fw_q <= pcpsc_pkg::fw_of(pcpsc_pkg::FW_RESET_MHZ);
      wrap_q <= 1'b0;
      clk_src_q <= 1'b0;
      band_q <= 2'h0;
      pump_q <= 11'h000;
    end else begin
      acc_q <= acc_d;
      pix_cnt_q <= pix_cnt_d;
      fw_q <= fw_d;
      wrap_q <= wrap_d;
      clk_src_q <= clk_src_d;
      band_q <= band_d;
      pump_q <= pump_d;
    end
  end

  // ************************************************************
  // phase shift and outputs
  // ************************************************************
  // clock and divider line sync share one tap
  pcpsc_tap_delay #(
    .W(2),
    .DEPTH(pcpsc_pkg::PHASE_TAPS)
  ) u_delay (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_w({wrap_q, clk_src_q}), // R07 R08 R22
    .sel(cfg.phase_tap),
    .out_q({line_sync_out, pixel_clk_out})
  );

  assign frame_sync_out = vs_q;
  assign green_sync_out = green_q;
  assign odd_field = odd_q;
  assign lines_per_frame = lines_out_q;
  assign vco_band_out = band_q;
  assign pump_ua_out = pump_q;
  assign freq_word_out = fw_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_div_range;
    @(posedge sys_clk) disable iff (rst)
      (cfg.divisor >= 12'h002 && $stable(cfg.divisor))
        |=> pix_cnt_q < cfg.divisor;
  endproperty
  a_div_range: assert property (p_div_range) // R01
    else $error("divider count left its range");

  property p_band;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> fw_q <= pcpsc_pkg::band_max($past(band_sel)) &&
                      fw_q >= pcpsc_pkg::band_min($past(band_sel),
                                                  $past(cfg.vco_low_gear));
  endproperty
  a_band: assert property (p_band) // R04
    else $error("frequency word outside selected band");

  property p_coast_hold;
    @(posedge sys_clk) disable iff (rst)
      (coast && fw_q >= lo && fw_q <= hi) |=> fw_q == $past(fw_q);
  endproperty
  a_coast_hold: assert property (p_coast_hold) // R10
    else $error("frequency moved during coast");

  property p_pump;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> pump_ua_out == pcpsc_pkg::pump_ua($past(pump_sel));
  endproperty
  a_pump: assert property (p_pump) // R06
    else $error("pump current does not follow code");

  property p_hs_pol;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> hs_q == ($past(line_sync_input) ~^
                               $past(cfg.line_sync_pol[0]));
  endproperty
  a_hs_pol: assert property (p_hs_pol) // R13
    else $error("line sync polarity wrong");

  property p_coast_pol;
    @(posedge sys_clk) disable iff (rst)
      (!$past(rst) && $past(coast_in) && $past(cfg.coast_pol[0]))
        |-> coast_act_q;
  endproperty
  a_coast_pol: assert property (p_coast_pol) // R12
    else $error("active high coast not seen");

  property p_int_coast;
    @(posedge sys_clk) disable iff (rst)
      (cfg.int_coast_en && vs_q && ref_edge && pix_cnt_q != 12'h000 &&
       fw_q > lo && fw_q < hi) |=> $stable(fw_q);
  endproperty
  a_int_coast: assert property (p_int_coast) // R11
    else $error("internal coast did not hold loop");

  property p_slicer;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) |-> cs_q == ($past(green_sync_input[7:3]) <
                               $past(cfg.slice_level));
  endproperty
  a_slicer: assert property (p_slicer) // R15
    else $error("slicer output wrong");

  property p_regen_count;
    @(posedge sys_clk) disable iff (rst)
      (!vs_rise && !regen) |=> $stable(lines_q);
  endproperty
  a_regen_count: assert property (p_regen_count) // R17
    else $error("line count moved without regenerated edge");

  property p_ref_sel;
    @(posedge sys_clk) disable iff (rst)
      (cfg.filt_ref_sel && edge_raw && !filt_edge && fw_q >= lo &&
       fw_q <= hi) |=> $stable(fw_q);
  endproperty
  a_ref_sel: assert property (p_ref_sel) // R20
    else $error("rejected edge reached the loop");

endmodule
`default_nettype wire

// ### pcpsc_video_src.sv
// video source model driving line sync, green samples, coast and ext clock
`timescale 1ns/1ps
`default_nettype none
module pcpsc_video_src (
  // clock
  input wire logic sys_clk,
  // source outputs
  output logic line_sync_input,
  output logic [7:0] green_sync_input,
  output logic coast_in,
  output logic ext_clk_in
);
  // ************************************************************
  // levels
  // ************************************************************
  // blank level sits above the slice, sync tip below it
  localparam logic [7:0] GREEN_BLANK = 8'hC0;
  localparam logic [7:0] GREEN_TIP = 8'h10;

  // idle values at time zero
  initial begin
    line_sync_input = 1'b0;
    green_sync_input = GREEN_BLANK;
    coast_in = 1'b0;
    ext_clk_in = 1'b0;
  end

  // ************************************************************
  // stimulus tasks, all but set_green launched just after a rising edge
  // ************************************************************
  // active high line sync pulse, then idle gap
  task automatic line_pulse(input int width, input int gap);
    @(posedge sys_clk);
    #1;
    line_sync_input = 1'b1;
    repeat (width) @(posedge sys_clk);
    #1;
    line_sync_input = 1'b0;
    repeat (gap) @(posedge sys_clk);
    #1;
  endtask

  // negative going sync tip on the green channel
  task automatic green_pulse(input int width);
    @(posedge sys_clk);
    #1;
    green_sync_input = GREEN_TIP;
    repeat (width) @(posedge sys_clk);
    #1;
    green_sync_input = GREEN_BLANK;
  endtask

  // static green sample
  task automatic set_green(input logic [7:0] v);
    green_sync_input = v;
  endtask

  // coast pin level
  task automatic set_coast(input logic v);
    @(posedge sys_clk);
    #1;
    coast_in = v;
  endtask

  // external clock level
  task automatic set_ext(input logic v);
    @(posedge sys_clk);
    #1;
    ext_clk_in = v;
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the pixel clock and sync control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ************************************************************
  // clock, reset and wiring
  // ************************************************************
  typedef struct packed {
    logic [2:0] pump;
    logic [1:0] band;
    logic [7:0] green;
    logic inv;
    logic [10:0] ua;
    logic gout;
  } pcpsc_row_type;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  pcpsc_pkg::pcpsc_cfg_type cfg;
  logic line_sync_input;
  logic [7:0] green_sync_input;
  logic coast_in;
  logic ext_clk_in;
  logic pixel_clk_out;
  logic line_sync_out;
  logic frame_sync_out;
  logic green_sync_out;
  logic odd_field;
  logic [11:0] lines_per_frame;
  logic [1:0] vco_band_out;
  logic [10:0] pump_ua_out;
  logic [19:0] freq_word_out;
  int n_mismatch = 0;
  int num_checks = 0;
  pcpsc_row_type rows [8];
  logic [19:0] w;
  logic hi;
  int n;
  int exp_n;
  int k;
  int taps [3] = '{0, 7, 31};

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  pcpsc_video_src i_src (
    .sys_clk(sys_clk), .line_sync_input(line_sync_input),
    .green_sync_input(green_sync_input), .coast_in(coast_in),
    .ext_clk_in(ext_clk_in)
  );

  pcpsc_top #(.SEP_N(1), .REGEN_HOLD(2)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .cfg(cfg),
    .line_sync_input(line_sync_input), .green_sync_input(green_sync_input),
    .coast_in(coast_in), .ext_clk_in(ext_clk_in),
    .pixel_clk_out(pixel_clk_out), .line_sync_out(line_sync_out),
    .frame_sync_out(frame_sync_out), .green_sync_out(green_sync_out),
    .odd_field(odd_field), .lines_per_frame(lines_per_frame),
    .vco_band_out(vco_band_out), .pump_ua_out(pump_ua_out),
    .freq_word_out(freq_word_out)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  // wait edges, then step just past the last one
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask

  // single bit compare
  task automatic chk_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  // vector compare
  task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp,
                         input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // watch frame sync for a number of edges
  task automatic watch_frame(input int c, output logic seen);
    seen = 1'b0;
    repeat (c) begin
      tick(1);
      if (frame_sync_out === 1'b1) seen = 1'b1;
    end
  endtask

  // counts and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // run limit
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    $display("FAIL t=%0t run limit reached", $time);
    final_report();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    cfg = '0;
    cfg.divisor = 12'h010;
    cfg.vco_low_gear = 1'b0;
    cfg.line_sync_pol = 2'h1;
    cfg.coast_pol = 2'h1;
    cfg.slice_level = 5'h10;
    cfg.sep_src_slicer = 1'b1;
    rows[0] = {3'h0, 2'h0, 8'h80, 1'b0, 11'h032, 1'b0};
    rows[1] = {3'h1, 2'h1, 8'h78, 1'b0, 11'h064, 1'b1};
    rows[2] = {3'h2, 2'h2, 8'h80, 1'b1, 11'h096, 1'b1};
    rows[3] = {3'h3, 2'h3, 8'h78, 1'b1, 11'h0FA, 1'b0};
    rows[4] = {3'h4, 2'h0, 8'h80, 1'b0, 11'h15E, 1'b0};
    rows[5] = {3'h5, 2'h1, 8'h78, 1'b1, 11'h1F4, 1'b0};
    rows[6] = {3'h6, 2'h2, 8'h80, 1'b1, 11'h2EE, 1'b1};
    rows[7] = {3'h7, 2'h3, 8'h78, 1'b0, 11'h5DC, 1'b1};
    tick(7);
    chk_vec(freq_word_out, 20'h0A000, "reset word");
    tick(1);
    rst = 1'b0;
    tick(2);
    // table of pump, band and slicer settings
    foreach (rows[i]) begin
      {cfg.pump_current_sel_2, cfg.pump_current_sel_1,
       cfg.pump_current_sel_0} = rows[i].pump;
      {cfg.vco_band_sel_hi, cfg.vco_band_sel_lo} = rows[i].band;
      cfg.green_out_inv = rows[i].inv;
      i_src.set_green(rows[i].green);
      tick(3);
      chk_vec(20'(pump_ua_out), 20'(rows[i].ua), "pump");
      chk_vec(20'(vco_band_out), 20'(rows[i].band), "band");
      chk_bit(green_sync_out, rows[i].gout, "slicer");
      $display("row %0d done", i);
    end
    tick(3);
    chk_bit(freq_word_out >= 20'h31999 && freq_word_out <= 20'h44000, 1'b1,
            "band 3 clamp");
    // mid-run reset
    i_src.set_green(8'hC0);
    {cfg.vco_band_sel_hi, cfg.vco_band_sel_lo} = 2'h0;
    {cfg.pump_current_sel_2, cfg.pump_current_sel_1,
     cfg.pump_current_sel_0} = 3'h4;
    cfg.green_out_inv = 1'b0;
    cfg.divisor = 12'h020;
    rst = 1'b1;
    tick(2);
    chk_vec(freq_word_out, 20'h0A000, "word in reset");
    chk_vec(20'(pump_ua_out), 20'h0, "pump in reset");
    chk_bit(line_sync_out, 1'b0, "line in reset");
    chk_bit(frame_sync_out, 1'b0, "frame in reset");
    chk_bit(odd_field, 1'b0, "field in reset");
    rst = 1'b0;
    tick(2);
    chk_vec(20'(pump_ua_out), 20'h0015E, "pump after reset");
    $display("reset test done");
    // coast pin active high: word holds, divider keeps wrapping
    i_src.set_coast(1'b1);
    tick(4);
    w = freq_word_out;
    n = 0;
    fork
      repeat (8) i_src.line_pulse(3, 30);
      repeat (1024) begin
        tick(1);
        if (line_sync_out === 1'b1) n++;
      end
    join
    exp_n = (1024 * 32'h0000A000) / (65536 * int'(cfg.divisor));
    chk_bit(n >= exp_n - 1 && n <= exp_n + 1, 1'b1, "wrap count");
    chk_vec(freq_word_out, w, "coast hold");
    // same pin level read as inactive once polarity is low
    cfg.coast_pol = 2'h0;
    hi = 1'b0;
    fork
      repeat (6) i_src.line_pulse(3, 30);
      repeat (200) begin
        tick(1);
        if (freq_word_out !== w) hi = 1'b1;
      end
    join
    chk_bit(hi, 1'b1, "coast released");
    i_src.set_coast(1'b0);
    tick(4);
    w = freq_word_out;
    repeat (4) i_src.line_pulse(3, 30);
    chk_vec(freq_word_out, w, "coast active low");
    cfg.coast_pol = 2'h1;
    $display("coast test done");
    // filtered reference drops an edge that comes too early
    cfg.filt_ref_sel = 1'b1;
    i_src.line_pulse(3, 5);
    w = freq_word_out;
    i_src.line_pulse(3, 30);
    chk_vec(freq_word_out, w, "early edge dropped");
    // internal coast from a long frame sync
    cfg.int_coast_en = 1'b1;
    fork
      i_src.green_pulse(300);
      begin
        tick(30);
        chk_bit(frame_sync_out, 1'b1, "long pulse passes");
        w = freq_word_out;
        repeat (4) i_src.line_pulse(3, 30);
        chk_vec(freq_word_out, w, "internal coast");
      end
    join
    cfg.int_coast_en = 1'b0;
    tick(10);
    // separator rejects short pulses, takes line input as source
    fork
      i_src.green_pulse(5);
      watch_frame(30, hi);
    join
    chk_bit(hi, 1'b0, "short pulse rejected");
    cfg.sep_src_slicer = 1'b0;
    fork
      i_src.line_pulse(20, 10);
      watch_frame(40, hi);
    join
    chk_bit(hi, 1'b1, "line source frame");
    // idle low line reads as active once polarity is low
    cfg.line_sync_pol = 2'h0;
    watch_frame(20, hi);
    chk_bit(hi, 1'b1, "line active low");
    cfg.line_sync_pol = 2'h1;
    cfg.sep_src_slicer = 1'b1;
    // line count between two frames
    i_src.green_pulse(20);
    tick(5);
    repeat (5) i_src.line_pulse(2, 10);
    i_src.green_pulse(20);
    tick(4);
    chk_vec(20'(lines_per_frame), 20'h5, "lines per frame");
    $display("sync test done");
    // phase taps on the external clock path
    cfg.ext_clk_sel = 1'b1;
    foreach (taps[i]) begin
      cfg.phase_tap = 5'(taps[i]);
      i_src.set_ext(1'b0);
      tick(40);
      i_src.set_ext(1'b1);
      k = 0;
      while (k < 40 && pixel_clk_out !== 1'b1) begin
        tick(1);
        k++;
      end
      chk_vec(20'(k), 20'(taps[i] + 4), "tap delay");
    end
    $display("phase test done");
    final_report();
  end
endmodule
`default_nettype wire
